// File: design/scrt_defs.svh
// Offsets, field positions, reset values and timing figures of the scratch/offset bank.
// Assumes a 20 MHz core clock; included by the package and the design modules.
`ifndef SCRT_DEFS_SVH
`define SCRT_DEFS_SVH
`define SCRT_ADDR_UNLOCK 8'h04
`define SCRT_ADDR_SCR1 8'h05
`define SCRT_ADDR_SCR2 8'h06
`define SCRT_ADDR_OFFSET 8'h07
`define SCRT_UNLOCK_BIT 15
`define SCRT_BUSY_BIT 14
`define SCRT_OFFSET_RST 16'h0000
`define SCRT_WORD_RST 16'h0000
`define SCRT_TEMP_MAX 16'h7FFF
`define SCRT_TEMP_MIN 16'h8000
`define SCRT_NVM_WORDS 4
`define SCRT_SCR1_LOC 2'h0
`define SCRT_SCR2_LOC 2'h1
`define SCRT_CLK_MHZ 20
`define SCRT_PROG_TIME_US 7000
`define SCRT_LOAD_TIME_US 1500
`define SCRT_PROG_CYCLES (`SCRT_PROG_TIME_US * `SCRT_CLK_MHZ)
`define SCRT_LOAD_CYCLES (`SCRT_LOAD_TIME_US * `SCRT_CLK_MHZ)
`endif

// File: design/scrt_pkg.sv
// Types shared by the scratch/offset bank and its non-volatile store.
// Assumes scrt_defs.svh is on the include path.
`include "scrt_defs.svh"
package scrt_pkg;
  typedef logic [15:0] scrt_word_t;
  typedef enum logic [1:0] {SCRT_IDLE, SCRT_LOAD, SCRT_PROG} scrt_nvm_state_t;
  typedef struct packed {
    scrt_nvm_state_t state;
    logic [17:0] cnt;
    logic [1:0] addr;
    scrt_word_t data;
    logic load_done;
  } scrt_nvm_t;
  typedef struct packed {
    logic unlock;
    scrt_word_t scr1;
    scrt_word_t scr2;
    scrt_word_t offset;
    scrt_word_t temp;
    logic temp_valid;
    scrt_word_t rdata;
    logic rd_valid;
  } scrt_core_t;
endpackage

// File: design/scrt_nvm_if.sv
// Link between the register bank and its non-volatile store.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`include "scrt_defs.svh"
interface scrt_nvm_if;
  logic prog_req;
  logic [1:0] prog_addr;
  logic [15:0] prog_data;
  logic busy;
  logic load_done;
  logic [`SCRT_NVM_WORDS-1:0][15:0] words;
  modport core (output prog_req, output prog_addr, output prog_data,
                input busy, input load_done, input words);
  modport nvm (input prog_req, input prog_addr, input prog_data,
               output busy, output load_done, output words);
endinterface

// File: design/scrt_nvm.sv
// Non-volatile word store: power-up load timing and word programming.
// Assumes requests arrive only while busy is low.
`timescale 1ns/1ps
`include "scrt_defs.svh"
module scrt_nvm
  import scrt_pkg::*;
#(
  parameter int PROG_CYCLES = `SCRT_PROG_CYCLES,
  parameter int LOAD_CYCLES = `SCRT_LOAD_CYCLES,
  parameter logic [63:0] NVM_INIT = 64'h5A3C_96E1_0F4B_D278  // Arbitrary factory ID
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  scrt_nvm_if.nvm bus
);
  scrt_nvm_t st_reg;
  scrt_nvm_t st_next;
  // Contents survive reset; only the factory image is preset, so one process writes it
  scrt_word_t mem [`SCRT_NVM_WORDS] = '{NVM_INIT[15:0], NVM_INIT[31:16],
                                        NVM_INIT[47:32], NVM_INIT[63:48]};
  logic done;

  always_comb begin
    st_next = st_reg;
    st_next.load_done = 1'b0;
    done = 1'b0;
    case (st_reg.state)
      SCRT_IDLE: begin
        if (bus.prog_req) begin
          st_next.state = SCRT_PROG;
          st_next.addr = bus.prog_addr;
          st_next.data = bus.prog_data;
          st_next.cnt = '0;
        end
      end
      SCRT_LOAD: begin
        done = (st_reg.cnt == 18'(LOAD_CYCLES - 1));
        st_next.cnt = st_reg.cnt + 18'h1;
        if (done) begin
          st_next.state = SCRT_IDLE;
          st_next.load_done = 1'b1;
        end
      end
      SCRT_PROG: begin
        done = (st_reg.cnt == 18'(PROG_CYCLES - 1));
        st_next.cnt = st_reg.cnt + 18'h1;
        if (done) begin
          st_next.state = SCRT_IDLE;
        end
      end
      default: begin
        st_next.state = SCRT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '{state: SCRT_LOAD, cnt: 18'h0, addr: 2'h0, data: 16'h0000, load_done: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (st_reg.state == SCRT_PROG && done) begin
      mem[st_reg.addr] <= st_reg.data;
    end
  end

  for (genvar g = 0; g < `SCRT_NVM_WORDS; g++) begin : g_words
    assign bus.words[g] = mem[g];
  end
  assign bus.busy = (st_reg.state != SCRT_IDLE);
  assign bus.load_done = st_reg.load_done;

  property p_prog_store;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_reg.state == SCRT_PROG && done) |=> (mem[$past(st_reg.addr)] == $past(st_reg.data));
  endproperty
  a_prog_store: assert property (p_prog_store) else $error("Programmed word not stored");

  property p_load_busy;
    @(posedge i_clk) disable iff (!i_rst_n)
      st_reg.load_done |-> !bus.busy && $past(bus.busy);
  endproperty
  a_load_busy: assert property (p_load_busy) else $error("Load end without busy");
endmodule

// File: design/scrt_bank.sv
// Scratch words, unlock control and temperature offset with saturating add.
// Assumes a same-clock serial-bus engine drives the register strobes.
// Notes on behaviour
// - Scratch word one at 05h, sixteen bits, read/write, backed by a stored word.
// - Locked writes change only the logic register, never the stored word.
// - Unlocked writes to a scratch word start programming its stored word.
// - Four stored words leave the factory with a unique ID; only words 0 and 1, behind the scratch words, are overwritable.
// - Scratch word two at 06h behaves exactly like scratch word one.
// - Offset register at 07h, sixteen bits, read/write, resets to 0000h.
// - Offset is added to the linearized result to give the reported temperature.
// - Offset uses 7.8125 m degC per bit, range plus or minus 256 degrees.
// - Offset has the same data format as the temperature result.
// - Out-of-range sums saturate at maximum or minimum, never wrap.
// - Unlock bit 15 selects logic-only writes (0) or programming (1).
// - Read-only busy bit 14 high during programming or power-up load.
// - Negative temperatures and offsets are two's complement.
`timescale 1ns/1ps
`include "scrt_defs.svh"
module scrt_bank
  import scrt_pkg::*;
#(
  parameter int PROG_CYCLES = `SCRT_PROG_CYCLES,
  parameter int LOAD_CYCLES = `SCRT_LOAD_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  output logic o_rd_valid,
  input wire logic i_temp_valid,
  input wire logic [15:0] i_temp_lin,
  output logic [15:0] o_temp,
  output logic o_temp_valid,
  output logic o_nvm_busy
);
  scrt_core_t st_reg;
  scrt_core_t st_next;
  scrt_nvm_if nvm_bus ();
  logic wr_scr1;
  logic wr_scr2;
  logic signed [16:0] sum;
  logic ovf_pos;
  logic ovf_neg;

  scrt_nvm #(
    .PROG_CYCLES(PROG_CYCLES),
    .LOAD_CYCLES(LOAD_CYCLES)
  ) u_nvm (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .bus(nvm_bus)
  );

  // Scratch writes while busy are dropped: a load would overwrite them, and a store still programming ignores the request
  assign wr_scr1 = i_wr_en && i_addr == `SCRT_ADDR_SCR1 && !nvm_bus.busy;
  assign wr_scr2 = i_wr_en && i_addr == `SCRT_ADDR_SCR2 && !nvm_bus.busy;

  // Two's complement sign-extended add, clamped at the code limits
  assign sum = 17'($signed(i_temp_lin)) + 17'($signed(st_reg.offset));
  assign ovf_pos = !sum[16] && sum[15];
  assign ovf_neg = sum[16] && !sum[15];

  always_comb begin
    st_next = st_reg;
    st_next.temp_valid = 1'b0;
    st_next.rd_valid = 1'b0;
    nvm_bus.prog_req = 1'b0;
    nvm_bus.prog_addr = `SCRT_SCR1_LOC;
    nvm_bus.prog_data = i_wdata;
    if (nvm_bus.load_done) begin
      st_next.scr1 = nvm_bus.words[`SCRT_SCR1_LOC];
      st_next.scr2 = nvm_bus.words[`SCRT_SCR2_LOC];
    end
    if (wr_scr1) begin
      st_next.scr1 = i_wdata;
      nvm_bus.prog_req = st_reg.unlock;
    end
    if (wr_scr2) begin
      st_next.scr2 = i_wdata;
      nvm_bus.prog_req = st_reg.unlock;
      nvm_bus.prog_addr = `SCRT_SCR2_LOC;
    end
    if (i_wr_en && i_addr == `SCRT_ADDR_UNLOCK) begin
      st_next.unlock = i_wdata[`SCRT_UNLOCK_BIT];
    end
    if (i_wr_en && i_addr == `SCRT_ADDR_OFFSET) begin
      st_next.offset = i_wdata;
    end
    if (i_temp_valid) begin
      st_next.temp_valid = 1'b1;
      if (ovf_pos) begin
        st_next.temp = `SCRT_TEMP_MAX;
      end else if (ovf_neg) begin
        st_next.temp = `SCRT_TEMP_MIN;
      end else begin
        st_next.temp = sum[15:0];
      end
    end
    if (i_rd_en) begin
      st_next.rd_valid = 1'b1;
      case (i_addr)
        `SCRT_ADDR_UNLOCK: begin
          st_next.rdata = 16'h0000;
          st_next.rdata[`SCRT_UNLOCK_BIT] = st_reg.unlock;
          st_next.rdata[`SCRT_BUSY_BIT] = nvm_bus.busy;
        end
        `SCRT_ADDR_SCR1: st_next.rdata = st_reg.scr1;
        `SCRT_ADDR_SCR2: st_next.rdata = st_reg.scr2;
        `SCRT_ADDR_OFFSET: st_next.rdata = st_reg.offset;
        default: st_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '{unlock: 1'b0, scr1: `SCRT_WORD_RST, scr2: `SCRT_WORD_RST,
                  offset: `SCRT_OFFSET_RST, temp: 16'h0000, temp_valid: 1'b0,
                  rdata: 16'h0000, rd_valid: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_rd_valid = st_reg.rd_valid;
  assign o_temp = st_reg.temp;
  assign o_temp_valid = st_reg.temp_valid;
  assign o_nvm_busy = nvm_bus.busy;

  property p_lock_no_prog;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr_en && (i_addr == `SCRT_ADDR_SCR1 || i_addr == `SCRT_ADDR_SCR2) && !st_reg.unlock)
      |-> !nvm_bus.prog_req;
  endproperty
  a_lock_no_prog: assert property (p_lock_no_prog) else $error("Locked write programmed");

  property p_unlock_prog;
    @(posedge i_clk) disable iff (!i_rst_n)
      ((wr_scr1 || wr_scr2) && st_reg.unlock)
      |-> nvm_bus.prog_req && nvm_bus.prog_data == i_wdata
      && nvm_bus.prog_addr == (wr_scr2 ? `SCRT_SCR2_LOC : `SCRT_SCR1_LOC) ##1 o_nvm_busy [*3];
  endproperty
  a_unlock_prog: assert property (p_unlock_prog) else $error("Unlocked write not programmed");

  property p_scr1_write;
    @(posedge i_clk) disable iff (!i_rst_n)
      wr_scr1 ##1 !wr_scr1 ##1 (i_rd_en && i_addr == `SCRT_ADDR_SCR1 && !nvm_bus.load_done)
      |=> o_rdata == $past(i_wdata, 3) && o_rd_valid;
  endproperty
  a_scr1_write: assert property (p_scr1_write) else $error("Scratch one readback wrong");

  property p_scr2_write;
    @(posedge i_clk) disable iff (!i_rst_n)
      wr_scr2 |=> st_reg.scr2 == $past(i_wdata);
  endproperty
  a_scr2_write: assert property (p_scr2_write) else $error("Scratch two not written");

  property p_unlock_read;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_rd_en && i_addr == `SCRT_ADDR_UNLOCK)
      |=> o_rdata[`SCRT_UNLOCK_BIT] == $past(st_reg.unlock)
      && o_rdata[`SCRT_BUSY_BIT] == $past(o_nvm_busy) && o_rdata[13:0] == 14'h0000;
  endproperty
  a_unlock_read: assert property (p_unlock_read) else $error("Unlock register read wrong");

  property p_sum;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_temp_valid && !ovf_pos && !ovf_neg)
      |=> o_temp_valid && o_temp == $past(i_temp_lin) + $past(st_reg.offset);
  endproperty
  a_sum: assert property (p_sum) else $error("Offset sum wrong");

  property p_sat;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_temp_valid && !i_temp_lin[15] && !st_reg.offset[15] && sum[15]
      |=> o_temp == `SCRT_TEMP_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("Sum did not saturate");

  property p_sat_neg;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_temp_valid && i_temp_lin[15] && st_reg.offset[15] && !sum[15]
      |=> o_temp == `SCRT_TEMP_MIN;
  endproperty
  a_sat_neg: assert property (p_sat_neg) else $error("Sum did not saturate low");

  property p_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      !i_temp_valid |=> $stable(o_temp) && !o_temp_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("Stored result altered");

  property p_offset_write;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr_en && i_addr == `SCRT_ADDR_OFFSET) |=> st_reg.offset == $past(i_wdata);
  endproperty
  a_offset_write: assert property (p_offset_write) else $error("Offset not written");

  property p_unlock_write;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr_en && i_addr == `SCRT_ADDR_UNLOCK)
      |=> st_reg.unlock == $past(i_wdata[`SCRT_UNLOCK_BIT]);
  endproperty
  a_unlock_write: assert property (p_unlock_write) else $error("Unlock not written");

  // Locked scratch writes keep the store idle, so its word cannot change
  property p_lock_idle;
    @(posedge i_clk) disable iff (!i_rst_n)
      ((wr_scr1 || wr_scr2) && !st_reg.unlock) |=> !o_nvm_busy;
  endproperty
  a_lock_idle: assert property (p_lock_idle) else $error("Locked write started store");

  property p_rd_pulse;
    @(posedge i_clk) disable iff (!i_rst_n)
      1'b1 |=> o_rd_valid == $past(i_rd_en);
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("Read valid not one cycle");
endmodule

// File: verif/scrt_host.sv
// Host controller model: register reads and writes on the bank's strobe bus.
// Assumes the bench calls its tasks from one process, one access at a time.
`timescale 1ns/1ps
module scrt_host (
  input wire logic i_clk,
  input wire logic i_busy,
  input wire logic [15:0] i_rdata,
  input wire logic i_rd_valid,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [15:0] o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'hFF;
    o_wdata = 16'hFFFF;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    // Scratch writes wait for the store; never reprograms word 0 by choice
    while ((a == 8'h05 || a == 8'h06) && i_busy !== 1'b0 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    @(posedge i_clk);
    o_wr_en <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    // Released lines show the inverse, not a stale copy
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_rd_en <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
    #1;
    d = (i_rd_valid === 1'b1) ? i_rdata : 16'hXXXX;
  endtask
endmodule

// File: verif/testbench.sv
// Self-checking bench for the scratch/offset bank with a host model.
// Assumes short store timings; stored-word defaults as in the store module.
`timescale 1ns/1ps
module testbench;
  import scrt_pkg::*;
  localparam int PROG_C = 8;
  localparam int LOAD_C = 5;
  // Arbitrary factory ID, matches the store's default
  localparam logic [63:0] INIT = 64'h5A3C_96E1_0F4B_D278;
  typedef struct {logic [15:0] lin; logic [15:0] off; logic [15:0] exp;} scrt_row_t;
  logic clk = 1'b0, rst_n = 1'b0, wr_en, rd_en, tv = 1'b0;
  logic [7:0] addr;
  logic [15:0] wdata, tl = 16'h0000, rdata, temp, d;
  logic rd_valid, temp_valid, busy;
  int mismatches = 0, num_checks = 0, cyc = 0, n;
  scrt_row_t rows[7] = '{'{16'h0100, 16'h0010, 16'h0110}, '{16'hFFF0, 16'h0005, 16'hFFF5},
    '{16'h7F00, 16'h0200, 16'h7FFF}, '{16'h8100, 16'hFE00, 16'h8000},
    '{16'h7FFF, 16'h8000, 16'hFFFF}, '{16'hC000, 16'hC000, 16'h8000},
    '{16'h0000, 16'h0000, 16'h0000}};

  always #25 clk = ~clk;

  scrt_bank #(.PROG_CYCLES(PROG_C), .LOAD_CYCLES(LOAD_C)) dut_u (.i_clk(clk), .i_rst_n(rst_n),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .o_rd_valid(rd_valid), .i_temp_valid(tv), .i_temp_lin(tl), .o_temp(temp),
    .o_temp_valid(temp_valid), .o_nvm_busy(busy));

  scrt_host host_u (.i_clk(clk), .i_busy(busy), .i_rdata(rdata), .i_rd_valid(rd_valid),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Pulse one result, check it the cycle after
  task automatic temp_chk(input logic [15:0] lin, input logic [15:0] exp);
    @(posedge clk);
    tv <= 1'b1;
    tl <= lin;
    @(posedge clk);
    tv <= 1'b0;
    tl <= ~lin;
    #1;
    chk({15'h0000, temp_valid}, 16'h0001, "temp valid");
    chk(temp, exp, "temp result");
  endtask

  // Bounded wait for the store to go idle
  task automatic wait_idle(output int cnt);
    cnt = 0;
    while (busy !== 1'b0 && cnt < 200) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, busy}, 16'h0001, "busy in reset");
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    wait_idle(n);
    chk(16'(n <= LOAD_C + 2 && n >= LOAD_C - 2), 16'h0001, "load length");
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    do_reset();
    host_u.rd(8'h05, d);
    chk(d, INIT[15:0], "factory word 0");
    host_u.rd(8'h07, d);
    chk(d, 16'h0000, "offset reset");
    host_u.rd(8'h04, d);
    chk(d, 16'h0000, "unlock reset");
    host_u.rd(8'h09, d);
    chk(d, 16'h0000, "unmapped read");
    @(posedge clk);
    #1;
    chk({15'h0000, rd_valid}, 16'h0000, "read valid pulse");
    host_u.wr(8'h05, 16'h1234);
    host_u.rd(8'h05, d);
    chk(d, 16'h1234, "locked write");
    foreach (rows[i]) begin
      host_u.wr(8'h07, rows[i].off);
      temp_chk(rows[i].lin, rows[i].exp);
    end
    host_u.wr(8'h07, 16'h0010);
    fork
      host_u.wr(8'h07, 16'h0020);
      temp_chk(16'h0100, 16'h0110);
    join
    temp_chk(16'h0100, 16'h0120);
    @(posedge clk);
    #1;
    chk({15'h0000, temp_valid}, 16'h0000, "temp valid pulse");
    chk(temp, 16'h0120, "temp held");
    host_u.wr(8'h04, 16'h8000);
    host_u.rd(8'h04, d);
    chk(d, 16'h8000, "unlock set");
    host_u.wr(8'h06, 16'hABCD);
    #1;
    chk({15'h0000, busy}, 16'h0001, "programming busy");
    host_u.rd(8'h04, d);
    chk(d, 16'hC000, "busy bit readback");
    host_u.rd(8'h06, d);
    chk(d, 16'hABCD, "unlocked write reg");
    wait_idle(n);
    chk(16'(n <= PROG_C), 16'h0001, "programming length");
    host_u.wr(8'h04, 16'h7FFF);
    host_u.rd(8'h04, d);
    chk(d, 16'h0000, "unlock read-only bits");
    do_reset();
    host_u.rd(8'h05, d);
    chk(d, INIT[15:0], "word 0 kept");
    host_u.rd(8'h06, d);
    chk(d, 16'hABCD, "word 1 programmed");
    host_u.rd(8'h07, d);
    chk(d, 16'h0000, "offset after reset");
    print_verdict();
  end
endmodule
